// ===== design/tefse_pkg.sv
package tefse_pkg;

    // widths
    localparam int unsigned NCH = 4;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // register offsets
    localparam logic [7:0] OFS_FLAGS = 8'h10;
    localparam logic [7:0] OFS_FORCE = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_MASK = 8'h24;

    // bit positions in flags, force, status and mask words
    localparam int unsigned BIT_UPD = 0;
    localparam int unsigned BIT_CH0 = 1;
    localparam int unsigned BIT_TRG = 6;
    localparam int unsigned BIT_OVC0 = 9;

    // bit positions in the enable word supplied from outside
    localparam int unsigned EN_DMA_UPD = 8;
    localparam int unsigned EN_DMA_CH0 = 9;
    localparam int unsigned EN_DMA_TRG = 14;

    // implemented bits and reset values
    localparam logic [31:0] FLAGS_MASK = 32'h0000_1e5f;
    localparam logic [31:0] FORCE_MASK = 32'h0000_005f;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [15:0] RST_CNT = 16'h0000;

    // slave mode encodings
    localparam logic [2:0] SMC_PAUSE = 3'h5;

    // sticky update: a set in the same cycle as a clear wins
    function automatic logic [31:0] sticky(
        input logic [31:0] cur,
        input logic [31:0] set,
        input logic [31:0] clr
    );
        return (cur & ~clr) | set;
    endfunction : sticky

    // packs the event vector into the flag word layout
    function automatic logic [31:0] evt_word(
        input logic upd,
        input logic [3:0] ch,
        input logic trg,
        input logic [3:0] ovc
    );
        logic [31:0] w;
        w = RST_WORD;
        w[BIT_UPD] = upd;
        w[BIT_CH0 +: 4] = ch;
        w[BIT_TRG] = trg;
        w[BIT_OVC0 +: 4] = ovc;
        return w;
    endfunction : evt_word

endpackage : tefse_pkg

// ===== design/tefse_trig_edge.sv
module tefse_trig_edge (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic trig_pin_in,
    input wire logic both_edges_in,
    input wire logic falling_in,
    output logic trig_level_out,
    output logic trig_event_out
);

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
    } tefse_edge_st_t;

    tefse_edge_st_t st_r;
    tefse_edge_st_t st_nxt;
    logic rise;
    logic fall;

    always_comb begin
        st_nxt = st_r;
        st_nxt.sync1 = trig_pin_in;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.prev = st_r.sync2;
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rise = st_r.sync2 & ~st_r.prev;
    assign fall = ~st_r.sync2 & st_r.prev;
    assign trig_level_out = st_r.sync2;
    // pause mode takes both edges, otherwise only the active one
    assign trig_event_out = both_edges_in ? (rise | fall) : (falling_in ? fall : rise);

endmodule : tefse_trig_edge

// ===== design/tefse_capture.sv
module tefse_capture (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [3:0] capture_in,
    input wire logic [15:0] counter_value_in,
    output logic [15:0] chan0_capture_value_out,
    output logic [15:0] chan1_capture_value_out,
    output logic [15:0] chan2_capture_value_out,
    output logic [15:0] chan3_capture_value_out
);

    typedef struct packed {
        logic [3:0][15:0] val;
    } tefse_cap_st_t;

    tefse_cap_st_t st_r;
    tefse_cap_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        for (int i = 0; i < tefse_pkg::NCH; i++) begin
            if (capture_in[i]) begin
                st_nxt.val[i] = counter_value_in;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            st_r <= '{val: {4{tefse_pkg::RST_CNT}}};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign chan0_capture_value_out = st_r.val[0];
    assign chan1_capture_value_out = st_r.val[1];
    assign chan2_capture_value_out = st_r.val[2];
    assign chan3_capture_value_out = st_r.val[3];

endmodule : tefse_capture

// ===== design/tefse_flags.sv
// What this block does
// - An input channel whose event flag is already set gets its over-capture flag (bits 9-12) set on a further capture, cleared only by software.
// - The trigger event flag at bit 6 is set on every trigger event and stays set until software clears it.
// - In pause slave mode both trigger edges make trigger events, otherwise only the active edge does.
// - A channel's event flag (bits 1-4) is set on capture in input mode and on compare in output mode, cleared only by software.
// - The update event flag at bit 0 is set on every update event and stays set until software clears it.
// - Writing one to the trigger force bit 6 sets the trigger flag with its requests if enabled, and the bit clears itself.
// - Writing one to a channel force bit (bits 1-4) forces an event on that channel, and the bit clears itself.
// - A forced channel event sets the channel's event flag and raises its interrupt or DMA request when enabled.
// - A forced event on an input channel copies the counter into its capture value and sets over-capture if the flag was already set.
// - Writing one to the update force bit 0 makes an update event that clears an up or center counter and reloads a down counter.
// - A forced update clears the prescaler counter in the same cycle as the counter reinit, and the force bit clears itself.
// - Interrupt requests follow flags only with their enable set, and DMA requests follow events only with their DMA enable set.
// - Pause slave mode gates the counter clock on while the trigger input is high and off while it is low.
module tefse_flags (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    input wire logic update_event_in,
    input wire logic [3:0] chan_event_in,
    input wire logic [3:0] chan_input_mode_in,
    input wire logic trigger_in,
    input wire logic trigger_falling_in,
    input wire logic [2:0] slave_mode_select_in,
    input wire logic count_down_in,
    input wire logic [15:0] dma_irq_enable_in,
    input wire logic [15:0] counter_value_in,
    output logic counter_clear_out,
    output logic counter_reload_out,
    output logic prescaler_clear_out,
    output logic counter_gate_out,
    output logic update_event_out,
    output logic trigger_event_out,
    output logic [3:0] chan_event_out,
    output logic [5:0] irq_req_out,
    output logic [5:0] dma_req_out,
    output logic [15:0] chan0_capture_value_out,
    output logic [15:0] chan1_capture_value_out,
    output logic [15:0] chan2_capture_value_out,
    output logic [15:0] chan3_capture_value_out,
    output logic irq_out
);

    typedef struct packed {
        logic [31:0] flags;
        logic [31:0] force_cmd;
        logic [31:0] status;
        logic [31:0] mask;
        logic [31:0] rdata;
    } tefse_st_t;

    tefse_st_t st_r;
    tefse_st_t st_nxt;

    logic pause_mode;
    logic trig_level;
    logic trig_hw_event;
    logic force_upd;
    logic force_trg;
    logic [3:0] force_ch;
    logic upd_evt;
    logic trg_evt;
    logic [3:0] ch_evt;
    logic [3:0] ch_flag;
    logic [3:0] ovc_evt;
    logic [3:0] force_capture;
    logic [31:0] set_word;
    logic [31:0] flag_clr;
    logic [31:0] status_clr;
    logic wr_flags;
    logic wr_force;
    logic wr_mask;
    logic rd_status;

    // trigger input sync and edge selection
    assign pause_mode = (slave_mode_select_in == tefse_pkg::SMC_PAUSE);

    tefse_trig_edge u_trig_edge (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .trig_pin_in(trigger_in),
        .both_edges_in(pause_mode),
        .falling_in(trigger_falling_in),
        .trig_level_out(trig_level),
        .trig_event_out(trig_hw_event)
    );

    // counter clock gate
    assign counter_gate_out = pause_mode ? trig_level : 1'b1;

    // address decode
    always_comb begin
        wr_flags = 1'b0;
        wr_force = 1'b0;
        wr_mask = 1'b0;
        rd_status = 1'b0;
        if (wr_in && addr_in == tefse_pkg::OFS_FLAGS) begin
            wr_flags = 1'b1;
        end else if (wr_in && addr_in == tefse_pkg::OFS_FORCE) begin
            wr_force = 1'b1;
        end else if (wr_in && addr_in == tefse_pkg::OFS_MASK) begin
            wr_mask = 1'b1;
        end
        if (rd_in && addr_in == tefse_pkg::OFS_STATUS) begin
            rd_status = 1'b1;
        end
    end

    // pending force commands, live for one cycle
    assign force_upd = st_r.force_cmd[tefse_pkg::BIT_UPD];
    assign force_trg = st_r.force_cmd[tefse_pkg::BIT_TRG];
    assign force_ch = st_r.force_cmd[tefse_pkg::BIT_CH0 +: 4];

    // merged event strobes
    assign upd_evt = update_event_in | force_upd;
    assign trg_evt = trig_hw_event | force_trg;
    assign ch_evt = chan_event_in | force_ch;

    // over-capture only for input channels whose flag is still set
    assign ch_flag = st_r.flags[tefse_pkg::BIT_CH0 +: 4];
    assign ovc_evt = ch_evt & chan_input_mode_in & ch_flag;

    // forced capture copies the counter
    assign force_capture = force_ch & chan_input_mode_in;

    tefse_capture u_capture (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .capture_in(force_capture),
        .counter_value_in(counter_value_in),
        .chan0_capture_value_out(chan0_capture_value_out),
        .chan1_capture_value_out(chan1_capture_value_out),
        .chan2_capture_value_out(chan2_capture_value_out),
        .chan3_capture_value_out(chan3_capture_value_out)
    );

    // flag set word, shared by flags and status
    assign set_word = tefse_pkg::evt_word(upd_evt, ch_evt, trg_evt, ovc_evt);

    // writing zero clears a flag, writing one keeps it
    assign flag_clr = wr_flags ? (~wdata_in & tefse_pkg::FLAGS_MASK) : tefse_pkg::RST_WORD;

    // status clears on its own read
    assign status_clr = rd_status ? tefse_pkg::FLAGS_MASK : tefse_pkg::RST_WORD;

    always_comb begin
        st_nxt = st_r;

        // sticky flags, set beats clear
        st_nxt.flags = tefse_pkg::sticky(st_r.flags, set_word, flag_clr);
        st_nxt.flags = st_nxt.flags & tefse_pkg::FLAGS_MASK;

        // event status for the interrupt line
        st_nxt.status = tefse_pkg::sticky(st_r.status, set_word, status_clr);
        st_nxt.status = st_nxt.status & tefse_pkg::FLAGS_MASK;

        // force bits self-clear after one cycle
        st_nxt.force_cmd = tefse_pkg::RST_WORD;
        if (wr_force) begin
            st_nxt.force_cmd = wdata_in & tefse_pkg::FORCE_MASK;
        end

        if (wr_mask) begin
            st_nxt.mask = wdata_in & tefse_pkg::FLAGS_MASK;
        end

        // read data stands only in the cycle after the read
        st_nxt.rdata = tefse_pkg::RST_WORD;
        if (rd_in) begin
            if (addr_in == tefse_pkg::OFS_FLAGS) begin
                st_nxt.rdata = st_r.flags;
            end else if (addr_in == tefse_pkg::OFS_STATUS) begin
                st_nxt.rdata = st_r.status;
            end else if (addr_in == tefse_pkg::OFS_MASK) begin
                st_nxt.rdata = st_r.mask;
            end else begin
                st_nxt.rdata = tefse_pkg::RST_WORD;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            st_r.flags <= tefse_pkg::RST_WORD;
            st_r.force_cmd <= tefse_pkg::RST_WORD;
            st_r.status <= tefse_pkg::RST_WORD;
            st_r.mask <= tefse_pkg::RST_WORD;
            st_r.rdata <= tefse_pkg::RST_WORD;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata_out = st_r.rdata;

    // forced update reinits counter and prescaler together
    assign counter_clear_out = force_upd & ~count_down_in;
    assign counter_reload_out = force_upd & count_down_in;
    assign prescaler_clear_out = force_upd;

    // event strobes towards the rest of the timer
    assign update_event_out = upd_evt;
    assign trigger_event_out = trg_evt;
    assign chan_event_out = ch_evt;

    // interrupt requests: order upd, ch0..ch3, trg
    assign irq_req_out[0] = st_r.flags[tefse_pkg::BIT_UPD]
        & dma_irq_enable_in[tefse_pkg::BIT_UPD];
    assign irq_req_out[4:1] = ch_flag & dma_irq_enable_in[tefse_pkg::BIT_CH0 +: 4];
    assign irq_req_out[5] = st_r.flags[tefse_pkg::BIT_TRG]
        & dma_irq_enable_in[tefse_pkg::BIT_TRG];

    // dma requests pulse with the event
    assign dma_req_out[0] = upd_evt & dma_irq_enable_in[tefse_pkg::EN_DMA_UPD];
    assign dma_req_out[4:1] = ch_evt & dma_irq_enable_in[tefse_pkg::EN_DMA_CH0 +: 4];
    assign dma_req_out[5] = trg_evt & dma_irq_enable_in[tefse_pkg::EN_DMA_TRG];

    // summary interrupt line
    assign irq_out = |(st_r.status & st_r.mask);

endmodule : tefse_flags

// ===== test/tefse_flags_sva.sv
module tefse_flags_sva (
    input wire logic clk_in, nrst_in, wr_in, rd_in, count_down_in, trigger_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in, rdata_out,
    input wire logic [2:0] slave_mode_select_in,
    input wire logic [15:0] dma_irq_enable_in,
    input wire logic counter_clear_out, counter_reload_out, prescaler_clear_out,
    input wire logic counter_gate_out, update_event_out, trigger_event_out, irq_out,
    input wire logic [3:0] chan_event_out,
    input wire logic [5:0] irq_req_out, dma_req_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    logic fw;
    logic [15:0] en;
    assign fw = wr_in && addr_in == tefse_pkg::OFS_FORCE;
    assign en = dma_irq_enable_in;
    property p_upd_flag; update_event_out ##1 en[0] |-> irq_req_out[0]; endproperty
    a_upd_flag: assert property (p_upd_flag) else $error("update flag missing");
    property p_ch_flag; chan_event_out[0] ##1 en[1] |-> irq_req_out[1]; endproperty
    a_ch_flag: assert property (p_ch_flag) else $error("channel flag missing");
    property p_trg_flag; trigger_event_out ##1 en[6] |-> irq_req_out[5]; endproperty
    a_trg_flag: assert property (p_trg_flag) else $error("trigger flag missing");
    property p_irq_en; (irq_req_out & ~{en[6], en[4:1], en[0]}) == 6'h00; endproperty
    a_irq_en: assert property (p_irq_en) else $error("irq request not enabled");
    property p_dma;
        dma_req_out == ({trigger_event_out, chan_event_out, update_event_out}
            & {en[14], en[12:9], en[8]});
    endproperty
    a_dma: assert property (p_dma) else $error("dma request mismatch");
    property p_upd_force;
        fw && wdata_in[0] |=> update_event_out && counter_reload_out == count_down_in
            && counter_clear_out != count_down_in;
    endproperty
    a_upd_force: assert property (p_upd_force) else $error("forced update wrong");
    property p_presc; prescaler_clear_out == (counter_clear_out || counter_reload_out); endproperty
    a_presc: assert property (p_presc) else $error("prescaler clear not paired");
    property p_selfclr; fw && wdata_in[0] ##1 !fw |=> !prescaler_clear_out; endproperty
    a_selfclr: assert property (p_selfclr) else $error("force bit not cleared");
    property p_trg_force; fw && wdata_in[6] |=> trigger_event_out; endproperty
    a_trg_force: assert property (p_trg_force) else $error("forced trigger missing");
    property p_ch_force; fw && wdata_in[1] |=> chan_event_out[0]; endproperty
    a_ch_force: assert property (p_ch_force) else $error("forced channel missing");
    property p_sticky;
        irq_req_out[0] && !(wr_in && addr_in == 8'h10 && !wdata_in[0]) ##1 en[0] |-> irq_req_out[0];
    endproperty
    a_sticky: assert property (p_sticky) else $error("update flag lost");
    property p_gate; slave_mode_select_in != 3'h5 |-> counter_gate_out; endproperty
    a_gate: assert property (p_gate) else $error("gate off outside pause");
    property p_pause;
        (slave_mode_select_in == 3'h5 && $stable(trigger_in))[*4] |-> counter_gate_out == trigger_in;
    endproperty
    a_pause: assert property (p_pause) else $error("pause gate wrong");
    c_force: cover property (fw && wdata_in[0]);
    c_trg: cover property (trigger_event_out);
    c_irq: cover property (irq_out);
endmodule : tefse_flags_sva

bind tefse_flags tefse_flags_sva u_sva (.clk_in, .nrst_in, .wr_in, .rd_in, .count_down_in,
    .trigger_in, .addr_in, .wdata_in, .rdata_out, .slave_mode_select_in, .dma_irq_enable_in,
    .counter_clear_out, .counter_reload_out, .prescaler_clear_out, .counter_gate_out,
    .update_event_out, .trigger_event_out, .irq_out, .chan_event_out, .irq_req_out, .dma_req_out);

// ===== test/tefse_flags_tb.sv
module tefse_flags_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0, nrst_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, update_event_in = 1'b0;
    logic trigger_in = 1'b0, trigger_falling_in = 1'b0, count_down_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0, rdata_out, v;
    logic [3:0] chan_event_in = 4'h0, chan_input_mode_in = 4'h0, chan_event_out;
    logic [2:0] slave_mode_select_in = 3'h0;
    logic [15:0] dma_irq_enable_in = 16'h0, counter_value_in = 16'h0;
    logic [15:0] chan0_capture_value_out, chan1_capture_value_out;
    logic [15:0] chan2_capture_value_out, chan3_capture_value_out;
    logic counter_clear_out, counter_reload_out, prescaler_clear_out, counter_gate_out;
    logic update_event_out, trigger_event_out, irq_out;
    logic [5:0] irq_req_out, dma_req_out;
    int err_count = 0, n_tests = 0;
    always #4 clk_in = ~clk_in;
    tefse_flags DUT (.clk_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
        .update_event_in, .chan_event_in, .chan_input_mode_in, .trigger_in, .trigger_falling_in,
        .slave_mode_select_in, .count_down_in, .dma_irq_enable_in, .counter_value_in,
        .counter_clear_out, .counter_reload_out, .prescaler_clear_out, .counter_gate_out,
        .update_event_out, .trigger_event_out, .chan_event_out, .irq_req_out, .dma_req_out,
        .chan0_capture_value_out, .chan1_capture_value_out, .chan2_capture_value_out,
        .chan3_capture_value_out, .irq_out);
    task stop_test();
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            $display("BAD %s exp %h got %h", n, e, s);
            err_count++;
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : wr
    task rc(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk($sformatf("reg %h", a), rdata_out, e);
    endtask : rc
    task ev(input logic u, input logic [3:0] c);
        @(posedge clk_in);
        update_event_in <= u;
        chan_event_in <= c;
        @(posedge clk_in);
        update_event_in <= 1'b0;
        chan_event_in <= 4'h0;
    endtask : ev
    task tg(input logic lvl, input logic [31:0] e);
        @(posedge clk_in);
        trigger_in <= lvl;
        repeat (6) @(posedge clk_in);
        rc(8'h10, e);
        wr(8'h10, 32'h0);
    endtask : tg
    initial begin
        #20000;
        err_count++;
        stop_test();
    end
    initial begin
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        rc(8'h10, 32'h0);
        rc(8'h14, 32'h0);
        wr(8'h30, 32'hffff);
        rc(8'h30, 32'h0);
        wr(8'h24, 32'h1e5f);
        rc(8'h24, 32'h1e5f);
        dma_irq_enable_in <= 16'h5f5f;
        ev(1'b1, 4'h0);
        rc(8'h10, 32'h1);
        chk("irq_req", {26'h0, irq_req_out}, 32'h1);
        wr(8'h10, 32'hffffffff);
        rc(8'h10, 32'h1);
        wr(8'h10, 32'hfffffffe);
        rc(8'h10, 32'h0);
        chan_input_mode_in <= 4'hf;
        ev(1'b0, 4'hf);
        ev(1'b0, 4'hf);
        rc(8'h10, 32'h1e1e);
        wr(8'h10, 32'h0);
        chan_input_mode_in <= 4'h0;
        ev(1'b0, 4'hf);
        ev(1'b0, 4'hf);
        rc(8'h10, 32'h1e);
        chk("irq", {31'h0, irq_out}, 32'h1);
        rc(8'h20, 32'h1e1f);
        rc(8'h20, 32'h0);
        chk("irq", {31'h0, irq_out}, 32'h0);
        wr(8'h24, 32'h0);
        ev(1'b1, 4'h0);
        chk("irq", {31'h0, irq_out}, 32'h0);
        wr(8'h24, 32'h1);
        @(posedge clk_in);
        #1 chk("irq", {31'h0, irq_out}, 32'h1);
        rc(8'h20, 32'h1);
        wr(8'h10, 32'h0);
        chan_input_mode_in <= 4'hf;
        counter_value_in <= 16'h1234;
        wr(8'h14, 32'h5f);
        rc(8'h10, 32'h5f);
        chk("cap01", {chan0_capture_value_out, chan1_capture_value_out}, 32'h12341234);
        chk("cap23", {chan2_capture_value_out, chan3_capture_value_out}, 32'h12341234);
        count_down_in <= 1'b1;
        counter_value_in <= 16'h4321;
        wr(8'h14, 32'h1f);
        #1 chk("reload", {31'h0, counter_reload_out}, 32'h1);
        rc(8'h14, 32'h0);
        rc(8'h10, 32'h1e5f);
        chk("cap03", {chan0_capture_value_out, chan3_capture_value_out}, 32'h43214321);
        count_down_in <= 1'b0;
        wr(8'h10, 32'h0);
        tg(1'b1, 32'h40);
        tg(1'b0, 32'h0);
        trigger_falling_in <= 1'b1;
        tg(1'b1, 32'h0);
        tg(1'b0, 32'h40);
        trigger_falling_in <= 1'b0;
        slave_mode_select_in <= 3'h5;
        tg(1'b1, 32'h40);
        chk("gate", {31'h0, counter_gate_out}, 32'h1);
        tg(1'b0, 32'h40);
        chk("gate", {31'h0, counter_gate_out}, 32'h0);
        stop_test();
    end
endmodule : tefse_flags_tb
